// [half_bridge_spi_control_tb.sv]
// Self-checking bench: host and device joined over the serial link
`timescale 1ns/1ps
module half_bridge_spi_control_tb;
   import hb_spi_pkg::*;
   // Short gap so the fault-clear spacing is reachable in a short run
   localparam int GAP = 2000;
   localparam logic [15:0] CMD_A = 16'h36e5;
   logic sys_clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic [3:0] addr_i = 4'h0;
   logic [31:0] wdata_i = 32'h0;
   logic wr_i = 1'b0;
   logic rd_i = 1'b0;
   logic [31:0] rdata_o;
   logic [31:0] rd_val;
   logic [NUM_HB-1:0] oc = 6'h00, ul = 6'h00, hs, ls, hs2, ls2;
   logic thermal_shutdown_latched = 1'b0, supply_fail_flag = 1'b0, tw = 1'b0, uls, overvoltage_lockout_en, rdy, rdy2;
   logic [15:0] sniff = 16'h0000;
   int err_count = 0;
   int comparisons = 0;
   hb_spi_if l1();
   hb_spi_if l2();
   hb_spi_host i_hb_spi_host (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .link(l1),
      .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o));
   hb_spi_device #(.CLEAR_GAP(GAP)) i_hb_spi_device (.sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i), .link(l1), .overcurrent_i(oc), .underload_i(ul),
      .thermal_shutdown_i(thermal_shutdown_latched), .supply_fail_i(supply_fail_flag), .thermal_warning_i(tw), .hs_on_o(hs),
      .ls_on_o(ls), .underload_shutdown_ctl_o(uls), .overvoltage_lockout_en_o(overvoltage_lockout_en),
      .ready_o(rdy));
   // Second device fed by the bench, so broken frames can be sent
   hb_spi_device #(.CLEAR_GAP(GAP)) i_hb_spi_device_b (.sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i), .link(l2), .overcurrent_i(oc), .underload_i(ul),
      .thermal_shutdown_i(thermal_shutdown_latched), .supply_fail_i(supply_fail_flag), .thermal_warning_i(tw), .hs_on_o(hs2),
      .ls_on_o(ls2), .underload_shutdown_ctl_o(), .overvoltage_lockout_en_o(),
      .ready_o(rdy2));
   hb_spi_link_monitor i_hb_spi_link_monitor (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .enable_i(l1.enable), .chip_select_n_i(l1.chip_select_n), .sck_i(l1.sck),
      .sdi_i(l1.sdi), .sdo_i(l1.sdo), .sdo_oe_i(l1.sdo_oe));
   initial begin
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   // Records the bits on the wire in arrival order
   always @(negedge l1.sck) begin
      if (!l1.chip_select_n) sniff <= {sniff[14:0], l1.sdi};
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (err_count == 0 && comparisons > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge sys_clk_i);
      wr_i <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge sys_clk_i);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge sys_clk_i);
      rd_i <= 1'b0;
      #1 rd_val = rdata_o;
   endtask
   // Busy is up well before 20 cycles, so a stale done is not mistaken
   task automatic frame(input logic [15:0] cmd);
      wr(REG_TX, {16'h0000, cmd});
      repeat (20) @(posedge sys_clk_i);
      for (int i = 0; i < 2000; i++) begin
         rd(REG_STATUS);
         if (rd_val[1:0] === 2'b10) return;
      end
      check("frame done", 32'h0, 32'h1);
      wrap_up();
   endtask
   task automatic wait_ready();
      for (int i = 0; i < 100; i++) begin
         @(posedge sys_clk_i);
         if (rdy === 1'b1 && rdy2 === 1'b1) return;
      end
      check("ready", 32'h0, 32'h1);
      wrap_up();
   endtask
   task automatic chain(input int n, input logic [31:0] d);
      @(posedge sys_clk_i);
      l2.chip_select_n <= 1'b0;
      repeat (8) @(posedge sys_clk_i);
      for (int i = n - 1; i >= 0; i--) begin
         l2.sdi <= d[i];
         l2.sck <= 1'b1;
         repeat (4) @(posedge sys_clk_i);
         l2.sck <= 1'b0;
         repeat (4) @(posedge sys_clk_i);
      end
      l2.sdi <= 1'b0;
      repeat (4) @(posedge sys_clk_i);
      l2.chip_select_n <= 1'b1;
      repeat (200) @(posedge sys_clk_i);
   endtask
   task automatic t_sleep();
      check("ready", rdy, 32'h0);
      check("high side", hs, 32'h0);
      wr(REG_TX, {16'h0000, CMD_A});
      repeat (20) @(posedge sys_clk_i);
      check("select", l1.chip_select_n, 32'h1);
   endtask
   task automatic t_drive();
      wr(REG_CTRL, 32'h1);
      l2.enable <= 1'b1;
      wait_ready();
      frame(CMD_A | 16'h4000);
      check("wire bits", sniff, CMD_A);
      check("high side", hs, 32'h20);
      check("low side", ls, 32'h0d);
      check("underload ctl", uls, 32'h1);
      check("lockout", overvoltage_lockout_en, 32'h1);
      frame(16'h0000);
      rd(REG_RX);
      check("diag", rd_val, 32'h16e4);
      check("high side off", hs, 32'h0);
      check("lockout off", overvoltage_lockout_en, 32'h0);
   endtask
   task automatic t_fault();
      frame(CMD_A);
      @(posedge sys_clk_i);
      thermal_shutdown_latched <= 1'b1;
      repeat (10) @(posedge sys_clk_i);
      thermal_shutdown_latched <= 1'b0;
      repeat (10) @(posedge sys_clk_i);
      check("shutdown", hs | ls, 32'h0);
      frame(CMD_A);
      rd(REG_RX);
      check("pre-bit set", rd_val[16], 32'h1);
      frame(CMD_A | 16'h8000);
      frame(CMD_A);
      rd(REG_RX);
      check("early clear", rd_val[16], 32'h1);
      repeat (GAP) @(posedge sys_clk_i);
      frame(CMD_A | 16'h8000);
      frame(CMD_A);
      rd(REG_RX);
      check("pre-bit clear", rd_val[16], 32'h0);
      check("restored", hs, 32'h20);
   endtask
   task automatic t_chain();
      // Shared fault inputs latched a thermal fault here too; clear it first
      chain(16, 32'h00008000);
      // Would enable five high sides if the short frame were taken
      chain(12, 32'h00000fff);
      check("short frame", hs2, 32'h0);
      chain(24, {8'h00, 8'ha5, CMD_A});
      check("chain high", hs2, 32'h20);
      check("chain low", ls2, 32'h0d);
      chain(20, 32'h0);
      check("odd frame", hs2, 32'h20);
   endtask
   task automatic t_diag();
      @(posedge sys_clk_i);
      oc <= 6'h20;
      ul <= 6'h01;
      supply_fail_flag <= 1'b1;
      tw <= 1'b1;
      repeat (10) @(posedge sys_clk_i);
      oc <= 6'h00;
      ul <= 6'h00;
      frame(CMD_A);
      rd(REG_RX);
      check("diag faults", rd_val, 32'hf6e5);
      check("overcurrent off", hs, 32'h0);
      check("underload off", ls, 32'h0c);
      @(posedge sys_clk_i);
      supply_fail_flag <= 1'b0;
      tw <= 1'b0;
   endtask
   task automatic t_off();
      wr(REG_CTRL, 32'h0);
      repeat (10) @(posedge sys_clk_i);
      check("ready off", rdy, 32'h0);
      check("drivers off", hs | ls, 32'h0);
      wr(REG_CTRL, 32'h1);
      wait_ready();
      frame(16'h0000);
      rd(REG_RX);
      check("cleared", rd_val, 32'h0);
   endtask
   initial begin
      l2.enable = 1'b0;
      l2.chip_select_n = 1'b1;
      l2.sck = 1'b0;
      l2.sdi = 1'b0;
      repeat (20) @(posedge sys_clk_i);
      sys_rst_i <= 1'b0;
      t_sleep();
      t_drive();
      t_fault();
      t_chain();
      t_diag();
      t_off();
      wrap_up();
   end
endmodule

// [hb_spi_device.sv]
// Half-bridge driver serial control: frame receive, check, latch and drive
// How it works
// R1: Enable low clears everything, drivers reset
// R2: Enable rise runs power-on sequence, then operates
// R3: Master keeps enable high during transfers; the host passes any REG_CTRL write to enable at once, even mid-frame
// R4: 16-bit full duplex frames plus thermal pre-bit
// R5: Clock and data low before select falls
// R6: MSB first, shifting only while selected
// R7: Input sampled on falling serial clock
// R8: Previous diagnostics shifted out on rising clock
// R9: First 16 bits exact, then multiples of 8
// R10: Valid frame latches last 16 bits
// R11: Serial output released while select high
// R12: Bit 15 clears all latched faults
// R13: Bit 14 reserved, written zero
// R14: Bit 13 enables underload shutdown per bridge
// R15: Bits 12..7 enable bridges 6..1
// R16: Bits 6..1 choose high or low side
// R17: Bit 0 enables overvoltage lockout
// R18: No shoot-through, dead time between sides
// R19: Thermal pre-bit shown until first rising clock
// R20: Diagnostic word layout fixed
// R21: Fault clear ignored within 150 us
// R22: Diagnostic word loaded when select falls
//
// The address map and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
module hb_spi_device
   import hb_spi_pkg::*;
#(
   parameter int CLEAR_GAP = CLEAR_GAP_CYCLES
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   hb_spi_if.device link,
   input wire logic [NUM_HB-1:0] overcurrent_i,
   input wire logic [NUM_HB-1:0] underload_i,
   input wire logic thermal_shutdown_i,
   input wire logic supply_fail_i,
   input wire logic thermal_warning_i,
   output logic [NUM_HB-1:0] hs_on_o,
   output logic [NUM_HB-1:0] ls_on_o,
   output logic underload_shutdown_ctl_o,
   output logic overvoltage_lockout_en_o,
   output logic ready_o
);
   typedef enum logic [2:0] {
      ST_SLEEP = 3'b001,
      ST_POR = 3'b010,
      ST_RUN = 3'b100
   } mode_e;

   typedef struct packed {
      logic [1:0] en_s;
      logic [1:0] cs_s;
      logic [1:0] sck_s;
      logic [1:0] sdi_s;
      logic cs_d1;
      logic sck_d1;
      mode_e mode;
      logic [7:0] por_cnt;
      logic [15:0] rx;
      logic [15:0] tx;
      logic [15:0] bit_cnt;
      logic ready;
      logic sdo;
      logic sdo_oe;
      logic [15:0] cmd;
      logic [NUM_HB-1:0] oc_lat;
      logic [NUM_HB-1:0] ul_lat;
      logic tsd_lat;
      logic [17:0] gap_cnt;
      logic [NUM_HB-1:0] hs;
      logic [NUM_HB-1:0] ls;
      logic [NUM_HB-1:0][7:0] dead;
   } state_s;

   state_s q, d;
   logic en, cs_n, sck, sdi;
   logic cs_fall, cs_rise, sck_rise, sck_fall, frame_ok, clear_ok;
   logic [NUM_HB-1:0] want_hs, want_ls, bridge_en;
   logic [15:0] diag;

   assign en = q.en_s[1];
   assign cs_n = q.cs_s[1];
   assign sck = q.sck_s[1];
   assign sdi = q.sdi_s[1];

   always_comb begin
      d = q;
      // Two-stage synchronisers; only stage two is looked at
      d.en_s = {q.en_s[0], link.enable};
      d.cs_s = {q.cs_s[0], link.chip_select_n};
      d.sck_s = {q.sck_s[0], link.sck};
      d.sdi_s = {q.sdi_s[0], link.sdi};
      d.cs_d1 = cs_n;
      d.sck_d1 = sck;
      cs_fall = q.cs_d1 && !cs_n;
      cs_rise = !q.cs_d1 && cs_n;
      // Serial clock ignored while deselected; master keeps it low then [R6] [R5]
      sck_rise = !cs_n && !q.sck_d1 && sck;
      sck_fall = !cs_n && q.sck_d1 && !sck;
      frame_ok = (q.bit_cnt >= 16'(FRAME_BITS))
         && (q.bit_cnt[2:0] == 3'h0); // [R9]
      clear_ok = (q.gap_cnt >= 18'(CLEAR_GAP)); // [R21]
      bridge_en = q.cmd[POS_UNDERLOAD_SD-1:POS_HB_ENABLE_LO] & ~q.oc_lat; // [R15]
      // Underload shuts only the bridge that saw it, when enabled [R14]
      if (q.cmd[POS_UNDERLOAD_SD]) begin
         bridge_en = bridge_en & ~q.ul_lat;
      end
      if (q.tsd_lat) begin
         bridge_en = '0;
      end
      want_hs = bridge_en & q.cmd[POS_HB_ENABLE_LO-1:POS_HB_CONFIG_LO]; // [R16]
      want_ls = bridge_en & ~q.cmd[POS_HB_ENABLE_LO-1:POS_HB_CONFIG_LO];
      diag = {|q.oc_lat, supply_fail_i, |q.ul_lat,
         q.cmd[POS_UNDERLOAD_SD-1:POS_HB_ENABLE_LO],
         q.cmd[POS_HB_ENABLE_LO-1:POS_HB_CONFIG_LO], thermal_warning_i}; // [R20]
      if (q.gap_cnt != 18'h3ffff) begin
         d.gap_cnt = q.gap_cnt + 18'h00001;
      end
      // Faults latch; a set in the clearing cycle survives below
      d.oc_lat = q.oc_lat | overcurrent_i;
      d.ul_lat = q.ul_lat | underload_i;
      d.tsd_lat = q.tsd_lat | thermal_shutdown_i;
      unique case (q.mode)
         ST_SLEEP: begin
            if (en) begin
               d.mode = ST_POR; // [R2]
            end
         end
         ST_POR: begin
            d.por_cnt = q.por_cnt + 8'h01;
            if (q.por_cnt == 8'(POR_CYCLES - 1)) begin
               d.mode = ST_RUN; // [R2]
            end
         end
         ST_RUN: begin
            if (cs_fall) begin
               d.tx = diag; // [R22]
               d.bit_cnt = '0;
            end
            if (sck_fall) begin
               d.rx = {q.rx[14:0], sdi}; // [R7] [R6]
               if (q.bit_cnt != 16'hffff) begin
                  d.bit_cnt = q.bit_cnt + 16'h0001;
               end
            end
            if (sck_rise) begin
               d.sdo = q.tx[15]; // [R8]
               d.tx = {q.tx[14:0], 1'b0};
            end else if (cs_fall) begin
               d.sdo = q.tsd_lat; // [R19] [R4]
            end else if (!q.sdo_oe) begin
               d.sdo = 1'b0;
            end
            d.sdo_oe = !cs_n; // [R11]
            if (cs_rise) begin
               if (frame_ok) begin
                  d.cmd = q.rx; // [R10]
                  if (q.rx[POS_STATUS_RESET] && clear_ok) begin
                     d.oc_lat = overcurrent_i; // [R12]
                     d.ul_lat = underload_i;
                     d.tsd_lat = thermal_shutdown_i;
                  end
               end
               d.gap_cnt = '0;
            end
         end
         default: d.mode = ST_SLEEP;
      endcase
      // Dead time: a side turns on only after both were off long enough [R18]
      for (int i = 0; i < NUM_HB; i++) begin
         if ((q.hs[i] && !want_hs[i]) || (q.ls[i] && !want_ls[i])) begin
            d.hs[i] = 1'b0;
            d.ls[i] = 1'b0;
            d.dead[i] = 8'(DEAD_CYCLES);
         end else if (q.dead[i] != 8'h00) begin
            d.dead[i] = q.dead[i] - 8'h01;
         end else begin
            d.hs[i] = want_hs[i];
            d.ls[i] = want_ls[i] & ~want_hs[i];
         end
      end
      if (!en) begin
         d = '0; // [R1]
         d.mode = ST_SLEEP;
         d.en_s = {q.en_s[0], link.enable};
         d.cs_s = {q.cs_s[0], link.chip_select_n};
         d.cs_d1 = 1'b1;
         d.gap_cnt = 18'h3ffff;
      end
      d.ready = (d.mode == ST_RUN);
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         q <= '0;
         q.mode <= ST_SLEEP;
         q.cs_s <= 2'b11;
         q.cs_d1 <= 1'b1;
         q.gap_cnt <= 18'h3ffff;
      end else begin
         q <= d;
      end
   end

   assign link.sdo = q.sdo;
   assign link.sdo_oe = q.sdo_oe;
   assign hs_on_o = q.hs;
   assign ls_on_o = q.ls;
   assign underload_shutdown_ctl_o = q.cmd[POS_UNDERLOAD_SD]; // [R14]
   assign overvoltage_lockout_en_o = q.cmd[POS_OVERVOLTAGE_LOCKOUT_EN]; // [R17]
   assign ready_o = q.ready;
endmodule

// [hb_spi_host.sv]
// Host end: serial master with a small register port for software
`timescale 1ns/1ps
module hb_spi_host
   import hb_spi_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   hb_spi_if.host link,
   input wire logic [3:0] addr_i,
   input wire logic [31:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rdata_o
);
   typedef enum logic [4:0] {
      H_IDLE = 5'b00001,
      H_SETUP = 5'b00010,
      H_LOW = 5'b00100,
      H_HIGH = 5'b01000,
      H_GAP = 5'b10000
   } host_e;

   typedef struct packed {
      host_e st;
      logic enable;
      logic cs_n;
      logic sck;
      logic sdi;
      logic [1:0] sdo_s;
      logic [15:0] tx;
      logic [16:0] rx;
      logic [4:0] nbits;
      logic [9:0] cnt;
      logic done;
      logic [31:0] rdata;
   } state_s;

   state_s q, d;

   always_comb begin
      d = q;
      d.sdo_s = {q.sdo_s[0], link.sdo};
      d.rdata = '0;
      if (rd_i) begin
         unique case (addr_i)
            REG_CTRL: d.rdata = {31'h0, q.enable};
            REG_TX: d.rdata = {16'h0, q.tx};
            REG_RX: d.rdata = {15'h0, q.rx};
            REG_STATUS: d.rdata = {30'h0, q.done, q.st != H_IDLE};
            default: d.rdata = '0;
         endcase
      end
      if (wr_i && addr_i == REG_CTRL) begin
         d.enable = wdata_i[0]; // [R3]
      end
      if (q.cnt != 10'h000) begin
         d.cnt = q.cnt - 10'h001;
      end
      unique case (q.st)
         H_IDLE: begin
            d.sck = 1'b0; // [R5]
            d.sdi = 1'b0;
            if (wr_i && addr_i == REG_TX && q.enable) begin
               d.tx = wdata_i[15:0] & ~(16'h0001 << POS_BRIDGE_SELECT); // [R13]
               d.cs_n = 1'b0;
               d.done = 1'b0;
               d.nbits = '0;
               d.cnt = 10'(CS_SETUP_CYCLES);
               d.st = H_SETUP;
            end
         end
         H_SETUP: begin
            if (q.cnt == 10'h000) begin
               // Pre-bit enters at bit 0 so sixteen shifts leave it at bit 16
               d.rx = {16'h0, q.sdo_s[1]}; // [R19]
               d.sdi = q.tx[15]; // [R6]
               d.cnt = 10'(HALF_SCK_CYCLES);
               d.st = H_HIGH;
               d.sck = 1'b1;
            end
         end
         H_HIGH: begin
            if (q.cnt == 10'h000) begin
               d.sck = 1'b0;
               d.rx = {q.rx[15:0], q.sdo_s[1]};
               d.tx = {q.tx[14:0], 1'b0};
               d.nbits = q.nbits + 5'h01;
               d.cnt = 10'(HALF_SCK_CYCLES);
               d.st = H_LOW;
            end
         end
         H_LOW: begin
            if (q.cnt == 10'h000) begin
               if (q.nbits == 5'(FRAME_BITS)) begin
                  d.cs_n = 1'b1;
                  d.sdi = 1'b0;
                  d.cnt = 10'(CS_HIGH_CYCLES);
                  d.st = H_GAP;
               end else begin
                  d.sdi = q.tx[15];
                  d.sck = 1'b1;
                  d.cnt = 10'(HALF_SCK_CYCLES);
                  d.st = H_HIGH;
               end
            end
         end
         H_GAP: begin
            if (q.cnt == 10'h000) begin
               d.done = 1'b1;
               d.st = H_IDLE;
            end
         end
         default: d.st = H_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         q <= '0;
         q.st <= H_IDLE;
         q.cs_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign link.enable = q.enable;
   assign link.chip_select_n = q.cs_n;
   assign link.sck = q.sck;
   assign link.sdi = q.sdi;
   assign rdata_o = q.rdata;
endmodule

// [hb_spi_if.sv]
// Serial link between the host controller and the half-bridge device
`timescale 1ns/1ps
interface hb_spi_if;
   logic enable;
   logic chip_select_n;
   logic sck;
   logic sdi;
   logic sdo;
   logic sdo_oe;
   modport device (input enable, input chip_select_n, input sck, input sdi,
      output sdo, output sdo_oe);
   modport host (output enable, output chip_select_n, output sck, output sdi,
      input sdo, input sdo_oe);
endinterface

// [hb_spi_link_monitor.sv]
// Checker for the host-to-device serial link
`timescale 1ns/1ps
module hb_spi_link_monitor (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic enable_i,
   input wire logic chip_select_n_i,
   input wire logic sck_i,
   input wire logic sdi_i,
   input wire logic sdo_i,
   input wire logic sdo_oe_i
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   logic [4:0] bits_q;
   // Clock rises inside one select window, cleared while deselected
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || chip_select_n_i) begin
         bits_q <= 5'h00;
      end else if ($rose(sck_i)) begin
         bits_q <= bits_q + 5'h01;
      end
   end
   a_sleep_no_select: assert property (!enable_i |-> chip_select_n_i)
      else $error("select low while disabled");
   a_idle_before_select: assert property ($fell(chip_select_n_i) |-> !sck_i && !sdi_i)
      else $error("clock or data high at select");
   a_clock_only_selected: assert property ($changed(sck_i) |-> !chip_select_n_i)
      else $error("clock moved while deselected");
   a_frame_sixteen: assert property ($rose(chip_select_n_i) |-> bits_q == 5'h10)
      else $error("frame not sixteen clocks");
   a_sdo_released: assert property (chip_select_n_i [*4] |-> !sdo_oe_i)
      else $error("output driven while deselected");
   a_sleep_no_drive: assert property (!enable_i [*4] |-> !sdo_oe_i)
      else $error("output driven while asleep");
   a_output_enabled: assert property ($fell(chip_select_n_i) |-> ##[1:5] sdo_oe_i)
      else $error("output not driven after select");
   a_prebit_held: assert property ($fell(chip_select_n_i) |-> ##5 $stable(sdo_i) [*3])
      else $error("first output bit not held");
   a_data_steady: assert property ($fell(sck_i) |-> $stable(sdi_i))
      else $error("data moved at sampling edge");
   c_frame_done: cover property ($rose(chip_select_n_i));
   c_prebit_set: cover property ($fell(chip_select_n_i) ##5 sdo_i);
   c_disable: cover property ($fell(enable_i));
endmodule

// [hb_spi_pkg.sv]
// Shared constants and types for the half-bridge serial control link
package hb_spi_pkg;
   localparam int FRAME_BITS = 16;
   localparam int CHAIN_BITS = 8;
   localparam int NUM_HB = 6;
   localparam int CLK_PERIOD_NS = 10;
   // Command frame field positions
   localparam int POS_STATUS_RESET = 15;
   localparam int POS_BRIDGE_SELECT = 14;
   localparam int POS_UNDERLOAD_SD = 13;
   localparam int POS_HB_ENABLE_LO = 7;
   localparam int POS_HB_CONFIG_LO = 1;
   localparam int POS_OVERVOLTAGE_LOCKOUT_EN = 0;
   // Diagnostic frame field positions
   localparam int POS_OVERCURRENT = 15;
   localparam int POS_SUPPLY_FAIL = 14;
   localparam int POS_UNDERLOAD = 13;
   localparam int POS_THERMAL_WARN = 0;
   localparam logic [15:0] CMD_RESET = 16'h0000;
   // Dead time between one side off and the other on
   localparam int DEAD_TIME_NS = 1500;
   localparam int DEAD_CYCLES = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Least spacing between frames for a fault-clear to count
   localparam int CLEAR_GAP_US = 150;
   localparam int CLEAR_GAP_CYCLES = (CLEAR_GAP_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Power-on sequence length after the enable rises
   localparam int POR_CYCLES = 16;
   // Host side: half period of the generated serial clock, and gaps
   localparam int HALF_SCK_CYCLES = 8;
   localparam int CS_SETUP_CYCLES = 8;
   localparam int CS_HIGH_CYCLES = 500;
   // Host register offsets
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_TX = 4'h1;
   localparam logic [3:0] REG_RX = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
endpackage
